// ==== logic/lcd_decoder_map.svh ====
// Address codes, RAM geometry, reset values and timing counts for the instruction decoder
// Assumes inclusion by the decoder package users; definitions only
`ifndef LCD_DECODER_MAP_SVH
`define LCD_DECODER_MAP_SVH

// Execution times in internal clock cycles
`define EXEC_CLEAR_CYC 16'h0136
`define EXEC_STD_CYC 16'h0005
// Character, glyph and icon RAM geometry; character fill byte
`define CHAR_RAM_DEPTH 80
`define CHAR_FILL_BYTE 8'h20
`define CHAR_LAST_ADDR 7'h4B
`define GLYPH_RAM_DEPTH 32
`define ICON_RAM_DEPTH 8
// Reset values
`define RST_LINE_COUNT 2'h3
// Annunciator/icon address codes
`define AIA_LED 4'h3
`define AIA_SHIFT 4'h4

`endif

// ==== logic/lcd_decoder_pkg.sv ====
// Types shared by the instruction decoder
// Assumes the map header supplies the numeric constants
package lcd_decoder_pkg;

  // Control fields loaded by instructions and annunciator data writes
  typedef struct packed {
    logic addr_inc;
    logic clock_divide_sel;
    logic [2:0] cursor_bits;
    logic display_on;
    logic font_width_sel;
    logic line_cursor;
    logic lcd_supply_on;
    logic sleep_mode;
    logic standby_mode;
    logic [1:0] line_count;
    logic [2:0] double_height_lines;
    logic [3:0] contrast_level;
    logic [2:0] start_line;
    logic [2:0] start_raster_row;
    logic annunciator_on;
    logic key_interrupt_enable;
    logic [1:0] key_scan_period;
    logic [2:0] led_outputs;
    logic [2:0] general_outputs;
    logic common_shift_dir;
    logic segment_shift_dir;
    logic osc_running;
  } ctrl_t;

  // Host access request
  typedef struct packed {
    logic valid;
    logic target_select;
    logic rd_wr_n;
    logic [7:0] data;
  } host_req_t;

  // Memory the address counter points at
  typedef enum logic [1:0] {
    TGT_CHAR = 2'h0,
    TGT_GLYPH = 2'h1,
    TGT_ICON = 2'h2,
    TGT_ANN = 2'h3
  } target_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_INIT = 3'h1,
    ST_IDLE = 3'h2,
    ST_BUSY = 3'h4
  } state_t;

endpackage

// ==== logic/lcd_instr_decoder.sv ====
// Instruction decoder, address counter and reset initialisation for the LCD controller
// Assumes host requests arrive as single-cycle pulses synchronous to sys_clk
`include "lcd_decoder_map.svh"

// What this block does
// - After each RAM read, step address by one per direction bit.
// - Status read returns busy, key-state, key-running and key data at once.
// - Clear display fills char RAM, zeroes address, busy 310 cycles.
// - Return home zeroes the address counter, busy five cycles.
// - Start-oscillator code sets oscillator running and leaves standby.
// - Entry mode loads address direction and clock-divide select.
// - Cursor control loads inverting, bottom-row and blink cursor bits.
// - Display on/off loads display-on, font width and line cursor.
// - Power control loads supply-on, sleep and standby bits.
// - Display control loads line count and double-height lines.
// - Contrast control loads upper start-line bit and contrast level.
// - Scroll control loads lower start-line bits and start raster row.
// - Annunciator address sets annunciator-on and a four-bit target address.
// - Glyph address instruction loads five-bit glyph address into counter.
// - Upper char address loads key interrupt, scan period, upper address.
// - Lower char address loads low bits of seven-bit address.
// - Data write goes to memory or outputs chosen by last address.
// - Data read returns byte from char, glyph or icon RAM.
// - During reset initialisation report busy and accept nothing.
// - Reset sets increment and clears divide, cursor, display, power bits.
// - Reset sets four lines and oscillator running, zeroes remaining fields and period.
// - Reset clear fills char RAM with 20H; glyph and icon untouched.
// - Char address stepping skips invalid locations past twelve per line.
// - Annunciator and LED addresses are never stepped after writes.
// - Instructions arriving while busy are ignored.
module lcd_instr_decoder (
  input wire logic sys_clk,
  input wire logic srst,
  input lcd_decoder_pkg::host_req_t host_req,
  input wire logic key_state_flag,
  input wire logic key_scan_running,
  input wire logic [4:0] key_scanned_data,
  output logic busy_flag,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output lcd_decoder_pkg::ctrl_t ctrl,
  output logic [6:0] addr_counter,
  output logic [3:0] annunciator_icon_address,
  output logic [11:0] annunciator_segs
);

  lcd_decoder_pkg::state_t state_q;
  lcd_decoder_pkg::target_t tgt_q;
  lcd_decoder_pkg::ctrl_t ctrl_q;
  logic [15:0] cnt_q;
  logic [6:0] ac_q;
  logic [3:0] aia_q;
  logic clearing_q;
  logic [7:0] char_ram [`CHAR_RAM_DEPTH];
  logic [5:0] glyph_ram [`GLYPH_RAM_DEPTH];
  logic [5:0] icon_ram [`ICON_RAM_DEPTH];
  logic [2:0][3:0] ann_q;
  logic accept;
  logic instr;
  logic wr_data;
  logic rd_ram;
  logic status_rd;
  logic step_ac;
  logic [7:0] d;

  // Next valid char address in the chosen direction, skipping gaps
  function automatic logic [6:0] char_step(input logic [6:0] a, input logic inc);
    logic [6:0] n;
    n = 7'h00;
    if (inc) begin
      n = (a[3:0] >= 4'hB) ? {a[6:4] + 3'h1, 4'h0} : a + 7'h01;
      if (n > `CHAR_LAST_ADDR) begin
        n = 7'h00;
      end
    end else begin
      if (a == 7'h00) begin
        n = `CHAR_LAST_ADDR;
      end else if (a[3:0] == 4'h0) begin
        n = {a[6:4] - 3'h1, 4'hB};
      end else begin
        n = a - 7'h01;
      end
    end
    return n;
  endfunction

  assign d = host_req.data;
  // Requests are taken only when idle; status read is always answered
  assign accept = host_req.valid && (state_q == lcd_decoder_pkg::ST_IDLE);
  assign status_rd = host_req.valid && !host_req.target_select && host_req.rd_wr_n;
  assign instr = accept && !host_req.target_select && !host_req.rd_wr_n;
  assign wr_data = accept && host_req.target_select && !host_req.rd_wr_n;
  assign rd_ram = accept && host_req.target_select && host_req.rd_wr_n;
  // Annunciator/LED targets keep their address fixed
  assign step_ac = (wr_data || rd_ram) && (tgt_q != lcd_decoder_pkg::TGT_ANN);

  // Sequencer: reset init, idle, busy countdown
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= lcd_decoder_pkg::ST_INIT;
      cnt_q <= `EXEC_CLEAR_CYC;
      clearing_q <= 1'b1;
    end else begin
      case (state_q)
        lcd_decoder_pkg::ST_INIT: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            state_q <= lcd_decoder_pkg::ST_IDLE;
            clearing_q <= 1'b0;
          end
        end
        lcd_decoder_pkg::ST_IDLE: begin
          if (instr && d == 8'h01) begin
            state_q <= lcd_decoder_pkg::ST_BUSY;
            cnt_q <= `EXEC_CLEAR_CYC;
            clearing_q <= 1'b1;
          end else if (instr || wr_data || rd_ram) begin
            state_q <= lcd_decoder_pkg::ST_BUSY;
            cnt_q <= `EXEC_STD_CYC;
          end
        end
        lcd_decoder_pkg::ST_BUSY: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            state_q <= lcd_decoder_pkg::ST_IDLE;
            clearing_q <= 1'b0;
          end
        end
        default: begin
          state_q <= lcd_decoder_pkg::ST_INIT;
          cnt_q <= `EXEC_CLEAR_CYC;
          clearing_q <= 1'b1;
        end
      endcase
    end
  end

  // Busy flag tracks the sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_flag <= 1'b1;
    end else begin
      busy_flag <= !(state_q == lcd_decoder_pkg::ST_IDLE && !(instr || wr_data || rd_ram)) &&
                   !(state_q != lcd_decoder_pkg::ST_IDLE && cnt_q == 16'h0001);
    end
  end

  // Control fields loaded by instructions and annunciator data writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= '0;
      ctrl_q.addr_inc <= 1'b1;
      ctrl_q.line_count <= `RST_LINE_COUNT;
      ctrl_q.osc_running <= 1'b1;
    end else if (instr) begin
      if (d == 8'h03) begin
        ctrl_q.osc_running <= 1'b1;
        ctrl_q.standby_mode <= 1'b0;
      end else if (d[7:2] == 6'b000001) begin
        ctrl_q.addr_inc <= d[1];
        ctrl_q.clock_divide_sel <= d[0];
      end else if (d[7:3] == 5'b00001) begin
        ctrl_q.cursor_bits <= d[2:0];
      end else if (d[7:3] == 5'b00010) begin
        ctrl_q.display_on <= d[2];
        ctrl_q.font_width_sel <= d[1];
        ctrl_q.line_cursor <= d[0];
      end else if (d[7:3] == 5'b00011) begin
        ctrl_q.lcd_supply_on <= d[2];
        ctrl_q.sleep_mode <= d[1];
        ctrl_q.standby_mode <= d[0];
      end else if (d[7:5] == 3'b001) begin
        ctrl_q.line_count <= d[4:3];
        ctrl_q.double_height_lines <= d[2:0];
      end else if (d[7:5] == 3'h2) begin
        ctrl_q.start_line[2] <= d[4];
        ctrl_q.contrast_level <= d[3:0];
      end else if (d[7:5] == 3'h3) begin
        ctrl_q.start_line[1:0] <= d[4:3];
        ctrl_q.start_raster_row <= d[2:0];
      end else if (d[7:5] == 3'h4) begin
        ctrl_q.annunciator_on <= d[4];
      end else if (d[7:5] == 3'h6) begin
        ctrl_q.key_interrupt_enable <= d[4];
        ctrl_q.key_scan_period <= d[3:2];
      end
    end else if (wr_data && tgt_q == lcd_decoder_pkg::TGT_ANN) begin
      if (aia_q == `AIA_LED) begin
        ctrl_q.general_outputs <= d[5:3];
        ctrl_q.led_outputs <= d[2:0];
      end else if (aia_q == `AIA_SHIFT) begin
        ctrl_q.common_shift_dir <= d[1];
        ctrl_q.segment_shift_dir <= d[0];
      end
    end
  end

  // Address counter and current target
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ac_q <= 7'h00;
      tgt_q <= lcd_decoder_pkg::TGT_CHAR;
      aia_q <= 4'h0;
    end else if (clearing_q) begin
      ac_q <= 7'h00;
      tgt_q <= lcd_decoder_pkg::TGT_CHAR;
    end else if (instr) begin
      if (d == 8'h01 || d == 8'h02) begin
        ac_q <= 7'h00;
        tgt_q <= lcd_decoder_pkg::TGT_CHAR;
      end else if (d[7:5] == 3'h4) begin
        aia_q <= d[3:0];
        if (d[3]) begin
          ac_q <= {4'h0, d[2:0]};
          tgt_q <= lcd_decoder_pkg::TGT_ICON;
        end else begin
          tgt_q <= lcd_decoder_pkg::TGT_ANN;
        end
      end else if (d[7:5] == 3'h5) begin
        ac_q <= {2'h0, d[4:0]};
        tgt_q <= lcd_decoder_pkg::TGT_GLYPH;
      end else if (d[7:5] == 3'h6) begin
        ac_q[6:5] <= d[1:0];
        tgt_q <= lcd_decoder_pkg::TGT_CHAR;
      end else if (d[7:5] == 3'h7) begin
        ac_q[4:0] <= d[4:0];
        tgt_q <= lcd_decoder_pkg::TGT_CHAR;
      end
    end else if (step_ac) begin
      case (tgt_q)
        lcd_decoder_pkg::TGT_CHAR: ac_q <= char_step(ac_q, ctrl_q.addr_inc);
        lcd_decoder_pkg::TGT_GLYPH: ac_q <= {2'h0, ac_q[4:0] + (ctrl_q.addr_inc ? 5'h01 : 5'h1F)};
        default: ac_q <= {4'h0, ac_q[2:0] + (ctrl_q.addr_inc ? 3'h1 : 3'h7)};
      endcase
    end
  end

  // Character RAM: written by host or by the clear fill
  always_ff @(posedge sys_clk) begin
    if (clearing_q) begin
      char_ram[cnt_q[6:0] % 7'(`CHAR_RAM_DEPTH)] <= `CHAR_FILL_BYTE;
    end else if (wr_data && tgt_q == lcd_decoder_pkg::TGT_CHAR) begin
      char_ram[ac_q] <= d;
    end
  end

  // Glyph and icon RAMs keep contents over reset
  always_ff @(posedge sys_clk) begin
    if (wr_data && tgt_q == lcd_decoder_pkg::TGT_GLYPH) begin
      glyph_ram[ac_q[4:0]] <= d[5:0];
    end
    if (wr_data && tgt_q == lcd_decoder_pkg::TGT_ICON) begin
      icon_ram[ac_q[2:0]] <= d[5:0];
    end
  end

  // Annunciator segment latches
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ann_q <= '0;
    end else if (wr_data && tgt_q == lcd_decoder_pkg::TGT_ANN && aia_q < `AIA_LED) begin
      ann_q[aia_q[1:0]] <= {d[6], d[4], d[2], d[0]};
    end
  end

  // Read answers: status without busy time, RAM data at current address
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= status_rd || rd_ram;
      if (status_rd) begin
        rd_data <= {busy_flag, key_state_flag, key_scan_running, key_scanned_data};
      end else if (rd_ram) begin
        case (tgt_q)
          lcd_decoder_pkg::TGT_CHAR: rd_data <= char_ram[ac_q];
          lcd_decoder_pkg::TGT_GLYPH: rd_data <= {2'h0, glyph_ram[ac_q[4:0]]};
          lcd_decoder_pkg::TGT_ICON: rd_data <= {2'h0, icon_ram[ac_q[2:0]]};
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end

  // Register copies for the outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl <= '0;
      addr_counter <= 7'h00;
      annunciator_icon_address <= 4'h0;
      annunciator_segs <= 12'h000;
    end else begin
      ctrl <= ctrl_q;
      addr_counter <= ac_q;
      annunciator_icon_address <= aia_q;
      annunciator_segs <= ann_q;
    end
  end

  // Busy stays high through reset init until the count ends
  chk_init_busy: assert property (@(posedge sys_clk) disable iff (srst)
    state_q == lcd_decoder_pkg::ST_INIT |-> busy_flag) else $error("busy low during init");
  // Clear display keeps busy for eight cycles and at cycle 300, and ends it by cycle 320
  sequence clr_taken;
    instr && d == 8'h01;
  endsequence
  chk_clear_busy: assert property (@(posedge sys_clk) disable iff (srst)
    clr_taken |=> busy_flag [*8]) else $error("clear busy too short");
  chk_clear_long: assert property (@(posedge sys_clk) disable iff (srst)
    clr_taken |-> ##300 busy_flag) else $error("clear busy ended early");
  chk_clear_ends: assert property (@(posedge sys_clk) disable iff (srst)
    clr_taken |-> ##[300:320] !busy_flag) else $error("clear busy not ended");
  // Return home holds busy for exactly five cycles and homes the counter
  sequence home_taken;
    instr && d == 8'h02;
  endsequence
  chk_std_exec: assert property (@(posedge sys_clk) disable iff (srst)
    home_taken |=> busy_flag [*5] ##1 !busy_flag) else $error("return home time wrong");
  chk_home_addr: assert property (@(posedge sys_clk) disable iff (srst)
    home_taken |=> ac_q == 7'h00 && tgt_q == lcd_decoder_pkg::TGT_CHAR)
    else $error("return home address wrong");
  // Requests during init or execution leave fields, target and counter alone
  chk_ignore_busy: assert property (@(posedge sys_clk) disable iff (srst)
    state_q != lcd_decoder_pkg::ST_IDLE && host_req.valid |=> $stable(ctrl_q) && $stable(tgt_q) && $stable(ac_q))
    else $error("accepted while busy");
  chk_status_fast: assert property (@(posedge sys_clk) disable iff (srst)
    status_rd |=> rd_valid && rd_data[7] == $past(busy_flag)) else $error("status read wrong");
  chk_read_valid: assert property (@(posedge sys_clk) disable iff (srst)
    rd_ram |=> rd_valid && busy_flag) else $error("ram read not answered");
  chk_entry_mode: assert property (@(posedge sys_clk) disable iff (srst)
    instr && d[7:2] == 6'b000001 |=> ctrl_q.addr_inc == $past(d[1])) else $error("entry mode not loaded");
  chk_ann_hold: assert property (@(posedge sys_clk) disable iff (srst)
    wr_data && tgt_q == lcd_decoder_pkg::TGT_ANN |=> $stable(ac_q)) else $error("annunciator addr moved");
  chk_glyph_step: assert property (@(posedge sys_clk) disable iff (srst)
    rd_ram && tgt_q == lcd_decoder_pkg::TGT_GLYPH && ctrl_q.addr_inc |=> ac_q[4:0] == $past(ac_q[4:0]) + 5'h01)
    else $error("glyph address not stepped");
  // A step from a valid char location never lands in a line gap
  chk_skip_gap: assert property (@(posedge sys_clk) disable iff (srst)
    step_ac && tgt_q == lcd_decoder_pkg::TGT_CHAR && ac_q[3:0] < 4'hC |=> ac_q[3:0] < 4'hC)
    else $error("char address in gap");

endmodule

// ==== testbench/host_model.sv ====
// Host side of the instruction link: sends one byte per call as a one-cycle pulse
// Assumes the decoder samples host_req on the rising edge of sys_clk
module host_model (
  input wire logic sys_clk,
  input wire logic busy_flag,
  output lcd_decoder_pkg::host_req_t host_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial host_req = '0;

  // Waits for idle unless told to barge in, then pulses valid for one cycle
  task automatic send(input logic ts, input logic rw, input logic [7:0] d, input bit wait_idle);
    int n;
    n = 0;
    while (wait_idle && busy_flag !== 1'b0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    host_req = '{1'b1, ts, rw, d};
    @(negedge sys_clk);
    host_req = '{1'b0, ~ts, ~rw, ~d}; // Released lines show a changing pattern
  endtask
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the instruction decoder
// Assumes host_model drives the request port; reads are scored from a queue
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic key_state_flag = 1'b0;
  logic key_scan_running = 1'b0;
  logic [4:0] key_scanned_data = 5'h0;
  lcd_decoder_pkg::host_req_t host_req;
  lcd_decoder_pkg::ctrl_t ctrl;
  lcd_decoder_pkg::ctrl_t e;
  logic busy_flag;
  logic rd_valid;
  logic [7:0] rd_data;
  logic [6:0] addr_counter;
  logic [3:0] aia;
  logic [11:0] segs;
  logic [7:0] exp_q[$];
  logic [7:0] w;
  logic [31:0] r;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #5 sys_clk = ~sys_clk;

  lcd_instr_decoder u_lcd_instr_decoder (.sys_clk(sys_clk), .srst(srst), .host_req(host_req),
    .key_state_flag(key_state_flag), .key_scan_running(key_scan_running),
    .key_scanned_data(key_scanned_data), .busy_flag(busy_flag), .rd_valid(rd_valid),
    .rd_data(rd_data), .ctrl(ctrl), .addr_counter(addr_counter),
    .annunciator_icon_address(aia), .annunciator_segs(segs));

  host_model u_host_model (.sys_clk(sys_clk), .busy_flag(busy_flag), .host_req(host_req));

  // Compare and count
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read results are matched against the oldest note
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected read", 64'h0000_0001, 64'h0000_0000);
      else chk("rd_data", {56'h0, exp_q.pop_front()}, {56'h0, rd_data});
    end
  end

  // One access, then count busy cycles; expn below zero skips the check
  task automatic xfer(input logic ts, input logic rw, input logic [7:0] d, input int expn);
    int n;
    n = 0;
    u_host_model.send(ts, rw, d, 1'b1);
    repeat (3) if (busy_flag !== 1'b1) @(negedge sys_clk);
    while (busy_flag === 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (expn >= 0) chk("busy cycles", 64'(expn), 64'(n));
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic rd(input logic ts, input logic [7:0] x);
    exp_q.push_back(x);
    xfer(ts, 1'b1, 8'h00, ts ? 5 : 0);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(negedge sys_clk);
    while (busy_flag !== 1'b0 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #200_000;
    n_mismatch++;
    end_sim();
  end

  // Main sequence
  initial begin
    void'($urandom(5308));
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    {key_state_flag, key_scan_running, key_scanned_data} = 7'($urandom());
    exp_q.push_back({1'b1, key_state_flag, key_scan_running, key_scanned_data});
    u_host_model.send(1'b0, 1'b1, 8'h00, 1'b0);
    u_host_model.send(1'b0, 1'b0, 8'h05, 1'b0);
    repeat (1000) @(negedge sys_clk);
    wait_idle();
    e = '0;
    e.addr_inc = 1'b1;
    e.line_count = 2'h3;
    e.osc_running = 1'b1;
    chk("ctrl reset", 64'(e), 64'(ctrl));
    chk("ac reset", 64'h0, 64'(addr_counter));
    $display("test reset done");
    xfer(1'b0, 1'b0, 8'hC0, 5);
    xfer(1'b0, 1'b0, 8'hE7, 5);
    rd(1'b1, 8'h20);
    chk("ac after read", 64'h8, 64'(addr_counter));
    w = 8'($urandom());
    xfer(1'b0, 1'b0, 8'hE5, 5);
    xfer(1'b1, 1'b0, w, 5);
    xfer(1'b0, 1'b0, 8'hE5, 5);
    rd(1'b1, w);
    xfer(1'b0, 1'b0, 8'hEB, 5);
    xfer(1'b1, 1'b0, 8'h41, 5);
    chk("ac skip", 64'h10, 64'(addr_counter));
    xfer(1'b0, 1'b0, 8'h04, 5);
    xfer(1'b0, 1'b0, 8'hE5, 5);
    rd(1'b1, w);
    chk("ac down", 64'h4, 64'(addr_counter));
    xfer(1'b0, 1'b0, 8'h06, 5);
    xfer(1'b0, 1'b0, 8'h01, 310);
    chk("ac clear", 64'h0, 64'(addr_counter));
    xfer(1'b0, 1'b0, 8'hE5, 5);
    rd(1'b1, 8'h20);
    xfer(1'b0, 1'b0, 8'h02, 5);
    chk("ac home", 64'h0, 64'(addr_counter));
    r = $urandom();
    xfer(1'b0, 1'b0, {3'b101, r[4:0]}, 5);
    chk("ac glyph", {59'h0, r[4:0]}, 64'(addr_counter));
    w = 8'($urandom());
    xfer(1'b1, 1'b0, w, 5);
    xfer(1'b0, 1'b0, {3'b101, r[4:0]}, 5);
    rd(1'b1, {2'h0, w[5:0]});
    chk("ac glyph step", {59'h0, 5'(r[4:0] + 5'h01)}, 64'(addr_counter));
    xfer(1'b0, 1'b0, 8'h9A, 5);
    xfer(1'b1, 1'b0, ~w, 5);
    xfer(1'b0, 1'b0, 8'h9A, 5);
    rd(1'b1, {2'h0, ~w[5:0]});
    chk("ac icon step", 64'h3, 64'(addr_counter));
    $display("test ram done");
    xfer(1'b0, 1'b0, 8'h93, 5);
    chk("aia", 64'h3, 64'(aia));
    repeat (2) begin
      r = $urandom();
      xfer(1'b1, 1'b0, r[7:0], 5);
    end
    chk("aia kept", 64'h3, 64'(aia));
    xfer(1'b0, 1'b0, 8'h94, 5);
    xfer(1'b1, 1'b0, 8'h02, 5);
    e.annunciator_on = 1'b1;
    {e.general_outputs, e.led_outputs} = r[5:0];
    {e.common_shift_dir, e.segment_shift_dir} = 2'b10;
    chk("ctrl outputs", 64'(e), 64'(ctrl));
    r = $urandom();
    xfer(1'b0, 1'b0, 8'h91, 5);
    xfer(1'b1, 1'b0, r[7:0], 5);
    chk("segs", {52'h0, 4'h0, r[6], r[4], r[2], r[0], 4'h0}, 64'(segs));
    chk("aia seg kept", 64'h1, 64'(aia));
    $display("test annunciator done");
    for (int i = 0; i < 18; i++) begin
      r = $urandom();
      case (i % 9)
        0: begin e.addr_inc = r[1]; e.clock_divide_sel = r[0]; xfer(0, 0, {6'h01, r[1:0]}, 5); end
        1: begin e.cursor_bits = r[2:0]; xfer(0, 0, {5'h01, r[2:0]}, 5); end
        2: begin {e.display_on, e.font_width_sel, e.line_cursor} = r[2:0]; xfer(0, 0, {5'h02, r[2:0]}, 5); end
        3: begin {e.line_count, e.double_height_lines} = r[4:0]; xfer(0, 0, {3'h1, r[4:0]}, 5); end
        4: begin e.start_line[2] = r[4]; e.contrast_level = r[3:0]; xfer(0, 0, {3'h2, r[4:0]}, 5); end
        5: begin e.start_line[1:0] = r[4:3]; e.start_raster_row = r[2:0]; xfer(0, 0, {3'h3, r[4:0]}, 5); end
        6: begin {e.key_interrupt_enable, e.key_scan_period} = r[2:0]; xfer(0, 0, {3'h6, r[2:0], 2'b00}, 5); end
        7: begin {e.lcd_supply_on, e.standby_mode} = {r[2], r[0]}; xfer(0, 0, {5'h03, r[2], 1'b0, r[0]}, 5); end
        default: begin e.standby_mode = 1'b0; e.osc_running = 1'b1; xfer(0, 0, 8'h03, -1); end
      endcase
      chk("ctrl fields", 64'(e), 64'(ctrl));
    end
    xfer(1'b0, 1'b0, 8'h1A, 5);
    e.lcd_supply_on = 1'b0;
    e.sleep_mode = 1'b1;
    chk("ctrl sleep", 64'(e), 64'(ctrl));
    $display("test fields done");
    u_host_model.send(1'b0, 1'b0, 8'h01, 1'b1);
    u_host_model.send(1'b0, 1'b0, {6'h01, ~e.addr_inc, ~e.clock_divide_sel}, 1'b0);
    wait_idle();
    chk("ctrl ignored", 64'(e), 64'(ctrl));
    {key_state_flag, key_scan_running, key_scanned_data} = 7'($urandom());
    rd(1'b0, {1'b0, key_state_flag, key_scan_running, key_scanned_data});
    repeat (4) @(negedge sys_clk);
    chk("reads pending", 64'h0, 64'(exp_q.size()));
    $display("test busy done");
    end_sim();
  end
endmodule
